// *** shared/lt_consts.vh ***
// Constants shared by the logic tile and its two sum-of-products arrays.
`ifndef LT_CONSTS_VH
`define LT_CONSTS_VH

// Register indices on the system bus port.
`define LT_REG_ACC0 3'h0
`define LT_REG_ACC1 3'h1
`define LT_REG_OPR0 3'h2
`define LT_REG_OPR1 3'h3
`define LT_REG_Q0 3'h4
`define LT_REG_Q1 3'h5
`define LT_REG_CTRL 3'h6
`define LT_REG_STAT 3'h7

// Control register fields and reset value.
`define LT_CTRL_Q0OUT 0
`define LT_CTRL_Q1OUT 1
`define LT_CTRL_RUN 2
`define LT_CTRL_SRST 3
`define LT_CTRL_ROUTE_LO 4
`define LT_CTRL_RST 8'h04
`define LT_DATA_RST 8'h00

// ALU functions.
`define LT_ALU_PASS 3'h0
`define LT_ALU_INC 3'h1
`define LT_ALU_DEC 3'h2
`define LT_ALU_ADD 3'h3
`define LT_ALU_SUB 3'h4
`define LT_ALU_AND 3'h5
`define LT_ALU_OR 3'h6
`define LT_ALU_XOR 3'h7

// Result destinations, load destinations and capture sources.
`define LT_DST_NONE 2'h0
`define LT_DST_ACC0 2'h1
`define LT_DST_ACC1 2'h2
`define LT_DST_STREAM 2'h3
`define LT_LD_ACC0 2'h0
`define LT_LD_ACC1 2'h1
`define LT_LD_OPR0 2'h2
`define LT_LD_OPR1 2'h3
`define LT_CAP_ACC0 2'h0
`define LT_CAP_ACC1 2'h1
`define LT_CAP_ALU 2'h2

// Queue depth in bytes.
`define LT_QDEPTH 3'h4

`endif

// *** verilog/lt_sop_array.v ***
// One sum-of-products array: 12 inputs, eight product terms, four outputs.
`timescale 1ns/1ps
`include "lt_consts.vh"

module lt_sop_array (
    input wire clock,
    input wire clkEn,
    input wire rst,
    input wire softRst,
    input wire [11:0] inBits,
    input wire [95:0] trueMask,
    input wire [95:0] compMask,
    input wire [31:0] orSel,
    input wire [3:0] regSel,
    output wire [3:0] outBits
);

    wire [7:0] term;
    wire [3:0] sum;
    reg [3:0] sumReg_r;

    genvar t;
    genvar o;
    generate
        for (t = 0; t < 8; t = t + 1)
        begin : gTerm
            // An input with neither mask bit set is left out; both set forces the term low.
            assign term[t] = &((inBits | ~trueMask[t*12 +: 12]) &
                               (~inBits | ~compMask[t*12 +: 12]));
        end
        for (o = 0; o < 4; o = o + 1)
        begin : gSum
            assign sum[o] = |(term & orSel[o*8 +: 8]);
        end
    endgenerate

    always @(posedge clock or posedge rst)
    begin
        if (rst)
            sumReg_r <= 4'h0;
        else if (clkEn)
        begin
            if (softRst)
                sumReg_r <= 4'h0;
            else
                sumReg_r <= sum;
        end
    end

    assign outBits = (regSel & sumReg_r) | (~regSel & sum);

endmodule // lt_sop_array

// *** verilog/lt_tile.v ***
// Logic tile: two sum-of-products arrays, 8-bit datapath, queues, status and control.
`timescale 1ns/1ps
`include "lt_consts.vh"

module lt_tile (
    input wire clock,
    input wire clkEn,
    input wire rst,
    input wire [2:0] busAddr,
    input wire busWrite,
    input wire busRead,
    input wire [7:0] busWdata,
    output wire [7:0] busRdata,
    input wire [2:0] aluFunc,
    input wire srcASel,
    input wire [1:0] srcBSel,
    input wire [1:0] resultDest,
    input wire loadQueue,
    input wire [1:0] loadDest,
    input wire captureQueue,
    input wire [1:0] captureSrc,
    input wire queueSel,
    output wire condZero,
    output wire condOnes,
    output wire condCarry,
    output wire cmpEq0,
    output wire cmpLt0,
    output wire cmpEq1,
    output wire cmpLt1,
    output wire q0Empty,
    output wire q0Full,
    output wire q1Empty,
    output wire q1Full,
    output wire [7:0] streamData,
    output wire streamValid,
    input wire streamReady,
    output wire [3:0] ctrlOut,
    input wire [3:0] statusIn,
    input wire [11:0] sop0In,
    input wire [95:0] sop0TrueMask,
    input wire [95:0] sop0CompMask,
    input wire [31:0] sop0OrSel,
    input wire [3:0] sop0RegSel,
    output wire [3:0] sop0Out,
    input wire [11:0] sop1In,
    input wire [95:0] sop1TrueMask,
    input wire [95:0] sop1CompMask,
    input wire [31:0] sop1OrSel,
    input wire [3:0] sop1RegSel,
    output wire [3:0] sop1Out
);

    reg [7:0] ctrl_r;
    reg [3:0] statusIn_r;
    reg [7:0] busRdata_r;
    reg [7:0] acc0_r;
    reg [7:0] acc1_r;
    reg [7:0] opr0_r;
    reg [7:0] opr1_r;
    reg [7:0] acc0_nxt;
    reg [7:0] acc1_nxt;
    reg [7:0] opr0_nxt;
    reg [7:0] opr1_nxt;
    reg [6:0] cond_r;
    reg [8:0] aluWide;
    reg [7:0] operB;
    reg [7:0] capData;
    reg [7:0] bufData0_r;
    reg [7:0] bufData1_r;
    reg bufWr_r;
    reg bufRd_r;
    reg [1:0] bufCnt_r;

    wire run;
    wire softRst;
    wire [1:0] qOutMode;
    wire [7:0] operA;
    wire [7:0] aluRes;
    wire toStream;
    wire bufInReady;
    wire bufPush;
    wire bufPop;
    wire dpGo;
    wire [1:0] qEmpty;
    wire [1:0] qFull;
    wire [15:0] qHead;
    wire [7:0] loadData;
    wire loadOk;

    // Clock gating and reset selection for the tile's own logic.
    assign run = clkEn & ctrl_r[`LT_CTRL_RUN];
    assign softRst = ctrl_r[`LT_CTRL_SRST];
    assign qOutMode = {ctrl_r[`LT_CTRL_Q1OUT], ctrl_r[`LT_CTRL_Q0OUT]};
    assign ctrlOut = ctrl_r[7:`LT_CTRL_ROUTE_LO];

    // A result bound for the stream waits while the buffer is full, stalling the whole step.
    assign toStream = (resultDest == `LT_DST_STREAM);
    assign dpGo = run & ~softRst & ~(toStream & ~bufInReady);

    assign operA = srcASel ? acc1_r : acc0_r;

    always @*
    begin
        case (srcBSel)
            2'h0: operB = acc0_r;
            2'h1: operB = acc1_r;
            2'h2: operB = opr0_r;
            default: operB = opr1_r;
        endcase
    end

    // Single-cycle ALU; bit 8 holds carry out of add and increment, borrow of subtract and decrement, zero for the logic functions.
    always @*
    begin
        case (aluFunc)
            `LT_ALU_PASS: aluWide = {1'b0, operA};
            `LT_ALU_INC: aluWide = {1'b0, operA} + 9'h001;
            `LT_ALU_DEC: aluWide = {1'b0, operA} - 9'h001;
            `LT_ALU_ADD: aluWide = {1'b0, operA} + {1'b0, operB};
            `LT_ALU_SUB: aluWide = {1'b0, operA} - {1'b0, operB};
            `LT_ALU_AND: aluWide = {1'b0, operA & operB};
            `LT_ALU_OR: aluWide = {1'b0, operA | operB};
            `LT_ALU_XOR: aluWide = {1'b0, operA ^ operB};
            default: aluWide = 9'h000;
        endcase
    end

    assign aluRes = aluWide[7:0];

    always @*
    begin
        case (captureSrc)
            `LT_CAP_ACC0: capData = acc0_r;
            `LT_CAP_ACC1: capData = acc1_r;
            default: capData = aluRes;
        endcase
    end

    // Two queues, each with its own storage; mode decides which side fills and drains.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gQueue
            reg [7:0] mem [0:3];
            reg [1:0] wrPtr_r;
            reg [1:0] rdPtr_r;
            reg [2:0] cnt_r;
            wire hit;
            wire pushReq;
            wire popReq;
            wire push;
            wire pop;
            wire [7:0] pushData;

            assign hit = (busAddr == ((g == 0) ? `LT_REG_Q0 : `LT_REG_Q1));
            assign pushReq = qOutMode[g] ? (dpGo & captureQueue & (queueSel == (g != 0))) :
                                           (clkEn & busWrite & hit);
            assign popReq = qOutMode[g] ? (clkEn & busRead & hit) :
                                          (dpGo & loadQueue & (queueSel == (g != 0)));
            assign pushData = qOutMode[g] ? capData : busWdata;
            assign push = pushReq & ~qFull[g];
            assign pop = popReq & ~qEmpty[g];
            assign qEmpty[g] = (cnt_r == 3'h0);
            assign qFull[g] = (cnt_r == `LT_QDEPTH);
            assign qHead[g*8 +: 8] = mem[rdPtr_r];

            always @(posedge clock)
            begin
                if (push)
                    mem[wrPtr_r] <= pushData;
            end

            always @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    wrPtr_r <= 2'h0;
                    rdPtr_r <= 2'h0;
                    cnt_r <= 3'h0;
                end
                else if (clkEn)
                begin
                    if (softRst)
                    begin
                        wrPtr_r <= 2'h0;
                        rdPtr_r <= 2'h0;
                        cnt_r <= 3'h0;
                    end
                    else
                    begin
                        if (push)
                            wrPtr_r <= wrPtr_r + 2'h1;
                        if (pop)
                            rdPtr_r <= rdPtr_r + 2'h1;
                        if (push & ~pop)
                            cnt_r <= cnt_r + 3'h1;
                        else if (pop & ~push)
                            cnt_r <= cnt_r - 3'h1;
                    end
                end
            end
        end
    endgenerate

    assign q0Empty = qEmpty[0];
    assign q0Full = qFull[0];
    assign q1Empty = qEmpty[1];
    assign q1Full = qFull[1];
    assign loadData = queueSel ? qHead[15:8] : qHead[7:0];
    // Loading from an empty queue or one turned outward leaves the target untouched.
    assign loadOk = loadQueue & ~qOutMode[queueSel] & ~qEmpty[queueSel];

    // Working register update: ALU result, then queue load, then firmware write wins.
    always @*
    begin
        acc0_nxt = acc0_r;
        acc1_nxt = acc1_r;
        opr0_nxt = opr0_r;
        opr1_nxt = opr1_r;
        if (dpGo)
        begin
            if (resultDest == `LT_DST_ACC0)
                acc0_nxt = aluRes;
            if (resultDest == `LT_DST_ACC1)
                acc1_nxt = aluRes;
            if (loadOk)
            begin
                case (loadDest)
                    `LT_LD_ACC0: acc0_nxt = loadData;
                    `LT_LD_ACC1: acc1_nxt = loadData;
                    `LT_LD_OPR0: opr0_nxt = loadData;
                    default: opr1_nxt = loadData;
                endcase
            end
        end
        if (busWrite)
        begin
            case (busAddr)
                `LT_REG_ACC0: acc0_nxt = busWdata;
                `LT_REG_ACC1: acc1_nxt = busWdata;
                `LT_REG_OPR0: opr0_nxt = busWdata;
                `LT_REG_OPR1: opr1_nxt = busWdata;
                default: acc0_nxt = acc0_nxt;
            endcase
        end
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            acc0_r <= `LT_DATA_RST;
            acc1_r <= `LT_DATA_RST;
            opr0_r <= `LT_DATA_RST;
            opr1_r <= `LT_DATA_RST;
            cond_r <= 7'h00;
        end
        else if (clkEn)
        begin
            if (softRst)
            begin
                acc0_r <= `LT_DATA_RST;
                acc1_r <= `LT_DATA_RST;
                opr0_r <= `LT_DATA_RST;
                opr1_r <= `LT_DATA_RST;
                cond_r <= 7'h00;
            end
            else
            begin
                acc0_r <= acc0_nxt;
                acc1_r <= acc1_nxt;
                opr0_r <= opr0_nxt;
                opr1_r <= opr1_nxt;
                if (dpGo)
                begin
                    cond_r[0] <= (aluRes == 8'h00);
                    cond_r[1] <= (aluRes == 8'hff);
                    cond_r[2] <= aluWide[8];
                    cond_r[3] <= (acc0_r == opr0_r);
                    cond_r[4] <= (acc0_r < opr0_r);
                    cond_r[5] <= (acc1_r == opr1_r);
                    cond_r[6] <= (acc1_r < opr1_r);
                end
            end
        end
    end

    assign condZero = cond_r[0];
    assign condOnes = cond_r[1];
    assign condCarry = cond_r[2];
    assign cmpEq0 = cond_r[3];
    assign cmpLt0 = cond_r[4];
    assign cmpEq1 = cond_r[5];
    assign cmpLt1 = cond_r[6];

    // Two-entry buffer between the ALU and the stream port.
    assign bufInReady = (bufCnt_r != 2'h2);
    assign bufPush = dpGo & toStream;
    assign bufPop = clkEn & (bufCnt_r != 2'h0) & streamReady;
    assign streamValid = (bufCnt_r != 2'h0);
    assign streamData = bufRd_r ? bufData1_r : bufData0_r;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bufData0_r <= 8'h00;
            bufData1_r <= 8'h00;
            bufWr_r <= 1'b0;
            bufRd_r <= 1'b0;
            bufCnt_r <= 2'h0;
        end
        else if (clkEn)
        begin
            if (softRst)
            begin
                bufWr_r <= 1'b0;
                bufRd_r <= 1'b0;
                bufCnt_r <= 2'h0;
            end
            else
            begin
                if (bufPush & ~bufWr_r)
                    bufData0_r <= aluRes;
                if (bufPush & bufWr_r)
                    bufData1_r <= aluRes;
                if (bufPush)
                    bufWr_r <= ~bufWr_r;
                if (bufPop)
                    bufRd_r <= ~bufRd_r;
                if (bufPush & ~bufPop)
                    bufCnt_r <= bufCnt_r + 2'h1;
                else if (bufPop & ~bufPush)
                    bufCnt_r <= bufCnt_r - 2'h1;
            end
        end
    end

    // Control, status capture and the registered read port.

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= `LT_CTRL_RST;
            statusIn_r <= 4'h0;
            busRdata_r <= 8'h00;
        end
        else if (clkEn)
        begin
            statusIn_r <= statusIn;
            if (busWrite & (busAddr == `LT_REG_CTRL))
                ctrl_r <= busWdata;
            if (busRead)
            begin
                case (busAddr)
                    `LT_REG_ACC0: busRdata_r <= acc0_r;
                    `LT_REG_ACC1: busRdata_r <= acc1_r;
                    `LT_REG_OPR0: busRdata_r <= opr0_r;
                    `LT_REG_OPR1: busRdata_r <= opr1_r;
                    `LT_REG_Q0: busRdata_r <= qHead[7:0];
                    `LT_REG_Q1: busRdata_r <= qHead[15:8];
                    `LT_REG_CTRL: busRdata_r <= ctrl_r;
                    `LT_REG_STAT: busRdata_r <= {statusIn_r, qFull[1], qEmpty[1],
                                                 qFull[0], qEmpty[0]};
                    default: busRdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign busRdata = busRdata_r;

    lt_sop_array uSop0 (
        .clock(clock),
        .clkEn(run),
        .rst(rst),
        .softRst(softRst),
        .inBits(sop0In),
        .trueMask(sop0TrueMask),
        .compMask(sop0CompMask),
        .orSel(sop0OrSel),
        .regSel(sop0RegSel),
        .outBits(sop0Out)
    );

    lt_sop_array uSop1 (
        .clock(clock),
        .clkEn(run),
        .rst(rst),
        .softRst(softRst),
        .inBits(sop1In),
        .trueMask(sop1TrueMask),
        .compMask(sop1CompMask),
        .orSel(sop1OrSel),
        .regSel(sop1RegSel),
        .outBits(sop1Out)
    );

endmodule // lt_tile

// *** tb/lt_tile_assertions.sv ***
// Checker for the logic tile ports: bus answers, control, queues, stream buffer and freezing.
`timescale 1ns/1ps
`include "lt_consts.vh"

module lt_tile_assertions (
    input wire clock,
    input wire rst,
    input wire clkEn,
    input wire [2:0] busAddr,
    input wire busWrite,
    input wire busRead,
    input wire [7:0] busWdata,
    input wire [7:0] busRdata,
    input wire [2:0] aluFunc,
    input wire [1:0] resultDest,
    input wire condCarry,
    input wire q0Empty,
    input wire q0Full,
    input wire q1Empty,
    input wire q1Full,
    input wire [7:0] streamData,
    input wire streamValid,
    input wire streamReady,
    input wire [3:0] ctrlOut,
    input wire [3:0] sop0RegSel,
    input wire [3:0] sop0Out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // The run and soft reset bits are not visible at the ports, so they are tracked here.
    reg runR;
    reg srstR;
    wire ctrlWr = clkEn && busWrite && busAddr == `LT_REG_CTRL;
    wire logicOp = aluFunc == `LT_ALU_PASS || aluFunc == `LT_ALU_AND ||
        aluFunc == `LT_ALU_OR || aluFunc == `LT_ALU_XOR;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            runR <= 1'b1;
            srstR <= 1'b0;
        end
        else if (ctrlWr)
        begin
            runR <= busWdata[`LT_CTRL_RUN];
            srstR <= busWdata[`LT_CTRL_SRST];
        end
    end

    property p_flags0; !(q0Empty && q0Full); endproperty
    a_flags0: assert property (p_flags0) else $error("queue zero empty and full together");
    property p_flags1; !(q1Empty && q1Full); endproperty
    a_flags1: assert property (p_flags1) else $error("queue one empty and full together");
    property p_status;
        clkEn && busRead && busAddr == `LT_REG_STAT |=>
            busRdata[3:0] == $past({q1Full, q1Empty, q0Full, q0Empty});
    endproperty
    a_status: assert property (p_status) else $error("status read flags wrong");
    property p_ctrlSet; ctrlWr |=> ctrlOut == $past(busWdata[7:4]); endproperty
    a_ctrlSet: assert property (p_ctrlSet) else $error("control outputs not written");
    property p_ctrlKeep; !ctrlWr |=> $stable(ctrlOut); endproperty
    a_ctrlKeep: assert property (p_ctrlKeep) else $error("control outputs moved");
    property p_rdKeep; !(clkEn && busRead) |=> $stable(busRdata); endproperty
    a_rdKeep: assert property (p_rdKeep) else $error("read data moved without read");
    property p_freeze;
        !clkEn |=> $stable({q0Empty, q0Full, q1Empty, q1Full, streamValid, busRdata});
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock gated");
    property p_sopReg;
        !clkEn && sop0RegSel == 4'hf ##1 sop0RegSel == 4'hf |-> $stable(sop0Out);
    endproperty
    a_sopReg: assert property (p_sopReg) else $error("registered array output moved");
    property p_streamHold;
        streamValid && !streamReady && !srstR |=> streamValid && $stable(streamData);
    endproperty
    a_streamHold: assert property (p_streamHold) else $error("stalled word lost");
    property p_logicCarry;
        clkEn && runR && !srstR && resultDest != `LT_DST_STREAM && logicOp |=> !condCarry;
    endproperty
    a_logicCarry: assert property (p_logicCarry) else $error("carry set by logic op");
endmodule // lt_tile_assertions

// *** tb/lt_stream_sink.sv ***
// Receiver model at the stream side of the tile, able to stall on request.
`timescale 1ns/1ps

module lt_stream_sink (
    input wire clock,
    input wire rst,
    input wire [7:0] streamData,
    input wire streamValid,
    input wire hold,
    output reg streamReady
);
    reg [7:0] words [0:7];
    integer count;

    // Ready follows the inverse of hold one edge late, so the sink answers slowly as a real one may.
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count <= 0;
            streamReady <= 1'b0;
        end
        else
        begin
            streamReady <= !hold;
            if (streamValid && streamReady)
            begin
                words[count[2:0]] <= streamData;
                count <= count + 1;
            end
        end
    end
endmodule // lt_stream_sink

// *** tb/lt_tile_tb_top.sv ***
// Top testbench of the logic tile: bus tasks, datapath steps, queue, stream and array tests.
`timescale 1ns/1ps
`include "lt_consts.vh"

module lt_tile_tb_top;
    reg clock = 0, rst = 1, clkEn = 1, busWrite = 0, busRead = 0, hold = 0;
    reg srcASel = 0, loadQueue = 0, captureQueue = 0, queueSel = 0;
    reg [2:0] busAddr = 0, aluFunc = 0;
    reg [7:0] busWdata = 0;
    reg [1:0] srcBSel = 2'h2, resultDest = 0, sel = 0;
    reg [3:0] statusIn = 0, sR = 0;
    reg [11:0] sIn = 0;
    reg [95:0] sT = 0, sC = 0;
    reg [31:0] sO = 0;
    reg [8:0] e;
    wire [7:0] busRdata, streamData;
    wire [3:0] ctrlOut, o0, o1;
    wire condZero, condOnes, condCarry, cmpEq0, cmpLt0, cmpEq1, cmpLt1;
    wire q0Empty, q0Full, q1Empty, q1Full, streamValid, streamReady;
    integer n_mismatch = 0, n_compared = 0, i;
    reg [11:0] vin [0:3];
    reg [3:0] vout [0:3];

    always #4 clock = ~clock;

    lt_tile u_dut (.clock(clock), .clkEn(clkEn), .rst(rst), .busAddr(busAddr),
        .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
        .aluFunc(aluFunc), .srcASel(srcASel), .srcBSel(srcBSel), .resultDest(resultDest),
        .loadQueue(loadQueue), .loadDest(sel), .captureQueue(captureQueue), .captureSrc(sel),
        .queueSel(queueSel), .condZero(condZero), .condOnes(condOnes), .condCarry(condCarry),
        .cmpEq0(cmpEq0), .cmpLt0(cmpLt0), .cmpEq1(cmpEq1), .cmpLt1(cmpLt1),
        .q0Empty(q0Empty), .q0Full(q0Full), .q1Empty(q1Empty), .q1Full(q1Full),
        .streamData(streamData), .streamValid(streamValid), .streamReady(streamReady),
        .ctrlOut(ctrlOut), .statusIn(statusIn), .sop0In(sIn), .sop0TrueMask(sT),
        .sop0CompMask(sC), .sop0OrSel(sO), .sop0RegSel(sR), .sop0Out(o0), .sop1In(sIn),
        .sop1TrueMask(sT), .sop1CompMask(sC), .sop1OrSel(sO), .sop1RegSel(sR), .sop1Out(o1));

    lt_stream_sink u_sink (.clock(clock), .rst(rst), .streamData(streamData),
        .streamValid(streamValid), .hold(hold), .streamReady(streamReady));

    task chk(input [7:0] g, input [7:0] x);
    begin
        n_compared = n_compared + 1;
        if (g !== x)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    end
    endtask

    task wr(input [2:0] a, input [7:0] d);
    begin
        @(negedge clock);
        busAddr = a;
        busWdata = d;
        busWrite = 1;
        @(negedge clock);
        busWrite = 0;
    end
    endtask

    task rdc(input [2:0] a, input [7:0] x);
    begin
        @(negedge clock);
        busAddr = a;
        busRead = 1;
        @(negedge clock);
        busRead = 0;
        chk(busRdata, x);
    end
    endtask

    // One datapath step; A and B follow srcASel and srcBSel, by default accumulator zero and operand register zero.
    task step(input [2:0] f, input [1:0] dst, input lq, input cq, input [1:0] s, input qs);
    begin
        @(negedge clock);
        aluFunc = f;
        resultDest = dst;
        loadQueue = lq;
        captureQueue = cq;
        sel = s;
        queueSel = qs;
        @(negedge clock);
        resultDest = 0;
        loadQueue = 0;
        captureQueue = 0;
    end
    endtask

    function [8:0] alu(input [2:0] f, input [7:0] a, input [7:0] b);
        case (f)
            3'h0: alu = {1'b0, a};
            3'h1: alu = {1'b0, a} + 9'h001;
            3'h2: alu = {1'b0, a} - 9'h001;
            3'h3: alu = {1'b0, a} + {1'b0, b};
            3'h4: alu = {1'b0, a} - {1'b0, b};
            3'h5: alu = {1'b0, a & b};
            3'h6: alu = {1'b0, a | b};
            default: alu = {1'b0, a ^ b};
        endcase
    endfunction

    task summarize;
    begin
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    // The tests need well under 2000 cycles; this limit only catches a hang.
    initial
    begin
        #40000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end

    initial
    begin
        vin[0] = 12'h001; vin[1] = 12'h003; vin[2] = 12'h801; vin[3] = 12'h800;
        vout[0] = 4'h1; vout[1] = 4'h0; vout[2] = 4'h9; vout[3] = 4'h8;
        repeat (4) @(negedge clock);
        rst = 0;
        for (i = 0; i < 4; i = i + 1)
            rdc(i, 8'h00);
        rdc(`LT_REG_CTRL, 8'h04);
        rdc(`LT_REG_STAT, 8'h05);
        // Term 0 is in0 and not in1 on output 0; term 7 is in11 on output 3.
        sT[0] = 1'b1;
        sC[1] = 1'b1;
        sT[95] = 1'b1;
        sO[0] = 1'b1;
        sO[31] = 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            @(negedge clock);
            sR = (i < 4) ? 4'h0 : 4'hf;
            sIn = vin[i % 4];
            if (i >= 4)
                @(negedge clock);
            #1;
            chk({o1, o0}, {vout[i % 4], vout[i % 4]});
        end
        wr(`LT_REG_ACC0, 8'hf0);
        wr(`LT_REG_OPR0, 8'h20);
        for (i = 0; i < 8; i = i + 1)
        begin
            step(i, `LT_DST_ACC1, 0, 0, 0, 0);
            e = alu(i, 8'hf0, 8'h20);
            chk({5'h0, condZero, condOnes, condCarry},
                {5'h0, e[7:0] == 8'h00, e[7:0] == 8'hff, e[8]});
            rdc(`LT_REG_ACC1, e[7:0]);
        end
        chk({6'h0, cmpEq0, cmpLt0}, 8'h00);
        rdc(`LT_REG_OPR0, 8'h20);
        // Accumulator one as both operands: 0xd0 + 0xd0 leaves 0xa0 and a carry.
        srcASel = 1;
        srcBSel = 2'h1;
        step(`LT_ALU_ADD, `LT_DST_ACC1, 0, 0, 0, 0);
        chk({7'h0, condCarry}, 8'h01);
        rdc(`LT_REG_ACC1, 8'ha0);
        srcASel = 0;
        srcBSel = 2'h2;
        wr(`LT_REG_OPR0, 8'hf0);
        step(`LT_ALU_SUB, `LT_DST_NONE, 0, 0, 0, 0);
        chk({4'h0, condZero, condCarry, cmpEq0, cmpLt0}, 8'h0a);
        for (i = 0; i < 5; i = i + 1)
            wr(`LT_REG_Q0, 8'h40 + i);
        chk({6'h0, q0Full, q0Empty}, 8'h02);
        rdc(`LT_REG_Q0, 8'h40);
        for (i = 0; i < 5; i = i + 1)
        begin
            step(`LT_ALU_PASS, `LT_DST_NONE, 1, 0, `LT_LD_OPR1, 0);
            rdc(`LT_REG_OPR1, 8'h40 + (i < 4 ? i : 3));
        end
        chk({4'h0, cmpEq1, cmpLt1, q0Full, q0Empty}, 8'h01);
        wr(`LT_REG_CTRL, 8'h06);
        wr(`LT_REG_Q1, 8'h99);
        chk({7'h0, q1Empty}, 8'h01);
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(`LT_REG_ACC0, 8'h50 + i);
            step(`LT_ALU_PASS, `LT_DST_NONE, 0, 1, `LT_CAP_ACC0, 1);
        end
        chk({6'h0, q1Full, q1Empty}, 8'h02);
        for (i = 0; i < 4; i = i + 1)
            rdc(`LT_REG_Q1, 8'h50 + i);
        step(`LT_ALU_INC, `LT_DST_NONE, 0, 1, `LT_CAP_ALU, 1);
        rdc(`LT_REG_Q1, 8'h55);
        wr(`LT_REG_CTRL, 8'ha4);
        chk({4'h0, ctrlOut}, 8'h0a);
        @(negedge clock);
        statusIn = 4'h9;
        rdc(`LT_REG_STAT, 8'h95);
        wr(`LT_REG_STAT, 8'h00);
        rdc(`LT_REG_STAT, 8'h95);
        @(negedge clock);
        clkEn = 0;
        wr(`LT_REG_ACC0, 8'h77);
        clkEn = 1;
        rdc(`LT_REG_ACC0, 8'h54);
        wr(`LT_REG_CTRL, 8'ha0);
        step(`LT_ALU_INC, `LT_DST_ACC0, 0, 0, 0, 0);
        rdc(`LT_REG_ACC0, 8'h54);
        wr(`LT_REG_CTRL, 8'h04);
        hold = 1;
        for (i = 1; i < 4; i = i + 1)
        begin
            wr(`LT_REG_ACC0, 8'h11 * i);
            step(`LT_ALU_PASS, `LT_DST_STREAM, 0, 0, 0, 0);
        end
        chk({streamValid, streamData[6:0]}, 8'h91);
        @(negedge clock);
        hold = 0;
        repeat (6) @(negedge clock);
        chk(u_sink.count, 8'h02);
        chk(u_sink.words[0], 8'h11);
        chk(u_sink.words[1], 8'h22);
        chk({7'h0, streamValid}, 8'h00);
        summarize;
    end
endmodule // lt_tile_tb_top

bind lt_tile lt_tile_assertions u_chk (.clock(clock), .rst(rst), .clkEn(clkEn),
    .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata),
    .busRdata(busRdata), .aluFunc(aluFunc), .resultDest(resultDest), .condCarry(condCarry),
    .q0Empty(q0Empty), .q0Full(q0Full), .q1Empty(q1Empty), .q1Full(q1Full),
    .streamData(streamData), .streamValid(streamValid), .streamReady(streamReady),
    .ctrlOut(ctrlOut), .sop0RegSel(sop0RegSel), .sop0Out(sop0Out));
